// *** acc_alu_pkg.sv ***
// Constants, register map and state layout of the accumulator ALU block
package acc_alu_pkg;

  // Data widths
  localparam int unsigned ACC_W  = 56;
  localparam int unsigned LONG_W = 48;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned EXT_W  = 8;
  localparam int unsigned INT_W  = 3;

  // Register byte offsets
  localparam logic [7:0] OFF_OPCODE  = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_A_EXT   = 8'h08;
  localparam logic [7:0] OFF_A_MID   = 8'h0c;
  localparam logic [7:0] OFF_A_LOW   = 8'h10;
  localparam logic [7:0] OFF_B_EXT   = 8'h14;
  localparam logic [7:0] OFF_B_MID   = 8'h18;
  localparam logic [7:0] OFF_B_LOW   = 8'h1c;
  localparam logic [7:0] OFF_X_HI    = 8'h20;
  localparam logic [7:0] OFF_X_LO    = 8'h24;
  localparam logic [7:0] OFF_Y_HI    = 8'h28;
  localparam logic [7:0] OFF_Y_LO    = 8'h2c;
  localparam logic [7:0] OFF_MOVE_HI = 8'h30;
  localparam logic [7:0] OFF_MOVE_LO = 8'h34;
  localparam logic [7:0] OFF_BUSY    = 8'h38;
  localparam logic [7:0] OFF_INT_ST  = 8'h3c;
  localparam logic [7:0] OFF_INT_CLR = 8'h40;
  localparam logic [7:0] OFF_INT_EN  = 8'h44;

  // Condition flag and scaling mode positions in the status register
  localparam int unsigned CC_C = 0;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_N = 3;
  localparam int unsigned CC_U = 4;
  localparam int unsigned CC_E = 5;
  localparam int unsigned CC_L = 6;
  localparam int unsigned CC_S = 7;
  localparam int unsigned SCALE_LSB = 10;

  // Scaling mode codes
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP   = 2'h2;

  // Opcode fields
  localparam int unsigned MV_EN_BIT  = 8;
  localparam int unsigned MV_SRC_BIT = 9;
  localparam int unsigned MV_RAW_BIT = 10;
  localparam logic [3:0] ABS_HI  = 4'h2;
  localparam logic [2:0] ABS_LO  = 3'h6;
  localparam logic [2:0] ADC_HI  = 3'h1;
  localparam logic [2:0] ADC_LO  = 3'h1;
  localparam logic [7:0] MOVE_OP = 8'h00;

  // Interrupt status bits
  localparam int unsigned INT_DONE    = 0;
  localparam int unsigned INT_OVF     = 1;
  localparam int unsigned INT_REFUSED = 2;

  // Timing in clock cycles
  localparam logic [3:0] ALU_CYCLES = 4'h2;

  // Values
  localparam logic [55:0] ACC_MIN = 56'h80_000000_000000;
  localparam logic [47:0] LIM_POS = 48'h7fffff_ffffff;
  localparam logic [47:0] LIM_NEG = 48'h800000_000000;

  typedef enum logic {ST_IDLE, ST_EXEC} fsm_t;

  typedef struct packed {
    fsm_t             fsm;
    logic [3:0]       cnt;
    logic [23:0]      opcode;
    logic             mv_lim;
    logic [1:0][55:0] acc;
    logic [47:0]      x;
    logic [47:0]      y;
    logic [15:0]      sr;
    logic [47:0]      move_data;
    logic [INT_W-1:0] int_st;
    logic [INT_W-1:0] int_en;
    logic [31:0]      prdata;
  } state_t;

endpackage : acc_alu_pkg

// *** acc_alu.sv ***
// Magnitude and add-with-carry accumulator ALU with parallel move, APB slave
`timescale 1ns/1ps
module acc_alu
  import acc_alu_pkg::*;
#(
  parameter logic [3:0] MV_EXTRA_CYCLES = 4'h2
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status
  output logic             irq,
  output logic             busy
);

  state_t st;
  state_t next_st;

  function automatic logic unmapped(input logic [7:0] a);
    unmapped = (a[1:0] != 2'h0) || (a > OFF_INT_EN);
  endfunction : unmapped

  function automatic logic uniform(input logic [9:0] v, input int unsigned n);
    logic all1;
    logic all0;
    all1 = 1'b1;
    all0 = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      if (i >= 10 - n)
      begin
        all1 = all1 & v[i];
        all0 = all0 & ~v[i];
      end
    end
    uniform = all1 | all0;
  endfunction : uniform

  // Integer portion is wider or narrower depending on scaling
  function automatic logic ext_in_use(input logic [55:0] v,
                                      input logic [1:0]  m);
    unique case (m)
      SCALE_DOWN: ext_in_use = ~uniform(v[55:46], 8);
      SCALE_UP:   ext_in_use = ~uniform(v[55:46], 10);
      default:    ext_in_use = ~uniform(v[55:46], 9);
    endcase
  endfunction : ext_in_use

  function automatic logic unnorm(input logic [55:0] v, input logic [1:0] m);
    unique case (m)
      SCALE_DOWN: unnorm = ~(v[48] ^ v[47]);
      SCALE_UP:   unnorm = ~(v[46] ^ v[45]);
      default:    unnorm = ~(v[47] ^ v[46]);
    endcase
  endfunction : unnorm

  function automatic logic growth(input logic [55:0] v, input logic [1:0] m);
    unique case (m)
      SCALE_DOWN: growth = v[47] ^ v[46];
      SCALE_UP:   growth = v[45] ^ v[44];
      default:    growth = v[46] ^ v[45];
    endcase
  endfunction : growth

  // Returns {limited, data}; raw reads bypass shifter and limiter
  function automatic logic [48:0] move_read(input logic [55:0] v,
                                            input logic [1:0]  m,
                                            input logic        raw);
    logic [55:0] s;
    s = v;
    if (m == SCALE_DOWN)
      s = {v[55], v[55:1]};
    else if (m == SCALE_UP)
      s = {v[54:0], 1'b0};
    if (raw)
      move_read = {1'b0, v[47:0]};
    else if (!uniform(s[55:46], 9))
      move_read = {1'b1, s[55] ? LIM_NEG : LIM_POS};
    else
      move_read = {1'b0, s[47:0]};
  endfunction : move_read

  logic        wr_acc;
  logic        start;
  logic        fin;
  logic        op_abs;
  logic        op_adc;
  logic        op_move;
  logic [55:0] res;
  logic [55:0] dv;
  logic [55:0] sv;
  logic [56:0] sum;
  logic        ovf;
  logic        car;
  logic [1:0]  mode;
  logic        dsel;

  assign wr_acc  = psel && penable && pwrite && !unmapped(paddr);
  assign start   = wr_acc && (paddr == OFF_OPCODE) && (st.fsm == ST_IDLE);
  assign fin     = (st.fsm == ST_EXEC) && (st.cnt == 4'h1);
  assign op_abs  = (st.opcode[7:4] == ABS_HI) && (st.opcode[2:0] == ABS_LO);
  assign op_adc  = (st.opcode[7:5] == ADC_HI) && (st.opcode[2:0] == ADC_LO);
  assign op_move = st.opcode[7:0] == MOVE_OP;
  assign mode    = st.sr[SCALE_LSB +: 2];
  assign dsel    = st.opcode[3];

  // Datapath; accumulators are frozen while busy, but a status write can still change the carry-in
  always_comb
  begin
    dv  = st.acc[dsel];
    sv  = st.opcode[4] ? {{8{st.y[47]}}, st.y} : {{8{st.x[47]}}, st.x};
    // carry taken from the full 56-bit sum
    sum = {1'b0, dv} + {1'b0, sv} + {56'h0, st.sr[CC_C]};
    res = dv;
    ovf = 1'b0;
    car = sum[56];
    if (op_abs)
    begin
      res = dv[55] ? 56'(~dv + 56'h1) : dv;
      // most negative input overflows, no clamping
      ovf = dv == ACC_MIN;
    end
    else if (op_adc)
    begin
      res = sum[55:0];
      ovf = (dv[55] == sv[55]) && (res[55] != dv[55]);
    end
  end

  always_comb
  begin
    logic [48:0]      mv;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;
    mv      = move_read(st.acc[pwdata[MV_SRC_BIT]], mode, pwdata[MV_RAW_BIT]);
    int_set = '0;
    int_clr = '0;
    next_st = st;

    // Read data is captured in the setup phase, ready in the access phase
    if (psel && !penable)
    begin
      unique case (paddr)
        OFF_OPCODE:  next_st.prdata = {8'h0, st.opcode};
        OFF_STATUS:  next_st.prdata = {16'h0, st.sr};
        OFF_A_EXT:   next_st.prdata = {24'h0, st.acc[0][55:48]};
        OFF_A_MID:   next_st.prdata = {8'h0, st.acc[0][47:24]};
        OFF_A_LOW:   next_st.prdata = {8'h0, st.acc[0][23:0]};
        OFF_B_EXT:   next_st.prdata = {24'h0, st.acc[1][55:48]};
        OFF_B_MID:   next_st.prdata = {8'h0, st.acc[1][47:24]};
        OFF_B_LOW:   next_st.prdata = {8'h0, st.acc[1][23:0]};
        OFF_X_HI:    next_st.prdata = {8'h0, st.x[47:24]};
        OFF_X_LO:    next_st.prdata = {8'h0, st.x[23:0]};
        OFF_Y_HI:    next_st.prdata = {8'h0, st.y[47:24]};
        OFF_Y_LO:    next_st.prdata = {8'h0, st.y[23:0]};
        OFF_MOVE_HI: next_st.prdata = {8'h0, st.move_data[47:24]};
        OFF_MOVE_LO: next_st.prdata = {8'h0, st.move_data[23:0]};
        OFF_BUSY:    next_st.prdata = {31'h0, st.fsm == ST_EXEC};
        OFF_INT_ST:  next_st.prdata = {29'h0, st.int_st};
        OFF_INT_EN:  next_st.prdata = {29'h0, st.int_en};
        default:     next_st.prdata = 32'h0;
      endcase
    end

    // Software writes; data registers are locked while an op runs so
    // the operand stays the value seen at issue
    if (wr_acc)
    begin
      unique case (paddr)
        OFF_OPCODE:
        begin
          if (st.fsm == ST_IDLE)
          begin
            next_st.opcode = pwdata[23:0];
            next_st.fsm    = ST_EXEC;
            next_st.cnt    = pwdata[MV_EN_BIT] ?
                             4'(ALU_CYCLES + MV_EXTRA_CYCLES) : ALU_CYCLES;
            next_st.mv_lim = 1'b0;
            if (pwdata[MV_EN_BIT])
            begin
              // move samples the accumulator before the result
              // raw low pair skips shift and limit
              next_st.move_data = mv[47:0];
              next_st.mv_lim    = mv[48];
            end
          end
          else
            int_set[INT_REFUSED] = 1'b1;
        end
        OFF_STATUS:  next_st.sr = pwdata[15:0];
        OFF_INT_CLR: int_clr = pwdata[INT_W-1:0];
        OFF_INT_EN:  next_st.int_en = pwdata[INT_W-1:0];
        default:
        begin
          if (st.fsm == ST_IDLE)
          begin
            unique case (paddr)
              OFF_A_EXT: next_st.acc[0][55:48] = pwdata[7:0];
              OFF_A_MID: next_st.acc[0][47:24] = pwdata[23:0];
              OFF_A_LOW: next_st.acc[0][23:0]  = pwdata[23:0];
              OFF_B_EXT: next_st.acc[1][55:48] = pwdata[7:0];
              OFF_B_MID: next_st.acc[1][47:24] = pwdata[23:0];
              OFF_B_LOW: next_st.acc[1][23:0]  = pwdata[23:0];
              OFF_X_HI:  next_st.x[47:24]      = pwdata[23:0];
              OFF_X_LO:  next_st.x[23:0]       = pwdata[23:0];
              OFF_Y_HI:  next_st.y[47:24]      = pwdata[23:0];
              OFF_Y_LO:  next_st.y[23:0]       = pwdata[23:0];
              default:   next_st.x             = st.x;
            endcase
          end
          // Read-only words sit above the data words; writing them is
          // harmless at any time, so it is not reported as refused
          else if (paddr < OFF_MOVE_HI)
            int_set[INT_REFUSED] = 1'b1;
        end
      endcase
    end

    // Execution; hardware flag updates land after a same-cycle status
    // write, so a flag event is never lost to software
    if (st.fsm == ST_EXEC)
    begin
      next_st.cnt = 4'(st.cnt - 4'h1);
      if (fin)
      begin
        next_st.fsm = ST_IDLE;
        int_set[INT_DONE] = 1'b1;
        if (st.mv_lim)
          next_st.sr[CC_L] = 1'b1;
        // plain move and unknown ops leave the ALU side alone
        if (op_abs || op_adc)
        begin
          next_st.acc[dsel] = res;
          next_st.sr[CC_N] = res[55];
          next_st.sr[CC_Z] = res == 56'h0;
          next_st.sr[CC_V] = ovf;
          // integer portion width set by scaling mode
          // extension and unnormalized by scaling mode
          next_st.sr[CC_E] = ext_in_use(res, mode);
          next_st.sr[CC_U] = unnorm(res, mode);
          // scaling flag is sticky growth detect
          if (growth(res, mode))
            next_st.sr[CC_S] = 1'b1;
          if (ovf)
            next_st.sr[CC_L] = 1'b1;
          // magnitude op leaves carry and mode bits alone
          if (op_adc)
            next_st.sr[CC_C] = car;
          int_set[INT_OVF] = ovf;
        end
      end
    end

    // Set wins over clear
    next_st.int_st = (st.int_st & ~int_clr) | int_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign prdata  = st.prdata;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && unmapped(paddr);
  assign irq     = |(st.int_st & st.int_en);
  assign busy    = st.fsm == ST_EXEC;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_busy2;
    busy [*2] ##1 !busy;
  endsequence

  chk_move_pre_value: assert property (
    start && pwdata[MV_EN_BIT] && pwdata[MV_RAW_BIT] |=>
      st.move_data == $past(st.acc[pwdata[MV_SRC_BIT]][47:0]))
    else $error("move did not read the pre-op accumulator");

  chk_move_nop: assert property (
    fin && op_move && !(wr_acc && paddr == OFF_STATUS) |=>
      st.acc == $past(st.acc) && st.sr[5:0] == $past(st.sr[5:0]))
    else $error("plain move altered the ALU state");

  chk_abs_magnitude: assert property (
    fin && op_abs && dv != ACC_MIN |=>
      st.acc[$past(dsel)] == ($past(dv[55]) ? 56'(-$past(dv)) : $past(dv)))
    else $error("magnitude result wrong");

  chk_abs_min_ovf: assert property (
    fin && op_abs && dv == ACC_MIN |=>
      st.acc[$past(dsel)] == ACC_MIN && st.sr[CC_V] && st.sr[CC_L])
    else $error("most negative magnitude not flagged");

  chk_op_timing: assert property (
    start && !pwdata[MV_EN_BIT] |=> s_busy2)
    else $error("op without move did not take two cycles");

  // Move length is a parameter, so the run is timed by its countdown
  chk_op_mv_timing: assert property (
    start && pwdata[MV_EN_BIT] |=>
      busy && st.cnt == 4'(ALU_CYCLES + MV_EXTRA_CYCLES))
    else $error("op with move loaded the wrong cycle count");

  chk_busy_count: assert property (
    busy && st.cnt != 4'h1 |=> busy && st.cnt == 4'($past(st.cnt) - 4'h1))
    else $error("operation counter did not step down");

  chk_busy_end: assert property (
    busy && st.cnt == 4'h1 |=> !busy)
    else $error("operation did not end on the last count");

  chk_adc_sum: assert property (
    fin && op_adc |=> {st.sr[CC_C], st.acc[$past(dsel)]} ==
      $past({1'b0, dv} + {1'b0, sv} + {56'h0, st.sr[CC_C]}))
    else $error("add-with-carry sum or carry wrong");

  chk_flags_nz: assert property (
    fin && (op_abs || op_adc) |=> st.sr[CC_N] == st.acc[$past(dsel)][55] &&
      st.sr[CC_Z] == (st.acc[$past(dsel)] == 56'h0))
    else $error("negative or zero flag wrong");

  chk_limit_sticky: assert property (
    st.sr[CC_L] && !(wr_acc && paddr == OFF_STATUS) |=> st.sr[CC_L])
    else $error("limit flag dropped without a status write");

  chk_mode_kept: assert property (
    fin && !(wr_acc && paddr == OFF_STATUS) |=>
      st.sr[15:8] == $past(st.sr[15:8]))
    else $error("mode bits changed by an operation");

endmodule : acc_alu

// *** apb_host.sv ***
// APB requester standing in for the decoder and the move path
`timescale 1ns/1ps
module apb_host (
  // Clock
  input  wire logic        pclk,
  // APB requester side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; hung is raised if pready never comes within the bound
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd   = prdata;
    err  = pslverr;
    hung = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep the old value alive
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : apb_host

// *** test_abs_adc_accumulator_alu_ops.sv ***
// Self-checking bench for the accumulator magnitude and add-with-carry ALU
`timescale 1ns/1ps
module test_abs_adc_accumulator_alu_ops
  import acc_alu_pkg::*;
;
  localparam logic [3:0] MV_X = 4'h3;
  localparam int         T_MV = 2 + MV_X;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        busy;
  logic [31:0] r;
  logic        e;
  int          err_count;
  int          compares;

  acc_alu #(.MV_EXTRA_CYCLES(MV_X)) u_dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .busy    (busy)
  );

  apb_host u_host (
    .pclk    (pclk),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  always #12.5 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic h;
    u_host.xfer(w, a, d, r, e, h);
    // Let registered outputs of the access edge settle
    #1;
    if (h)
    begin
      check("pready", 32'h1, 32'h0);
      give_verdict();
    end
  endtask : bus

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), x, r);
  endtask : chk_reg

  task automatic acc_io(input logic w, input logic [7:0] a,
                        input logic [55:0] v);
    logic [31:0] f [3];
    f = '{{24'h0, v[55:48]}, {8'h0, v[47:24]}, {8'h0, v[23:0]}};
    for (int i = 0; i < 3; i++)
      if (w)
        bus(1'b1, a + 8'(4 * i), f[i]);
      else
        chk_reg(a + 8'(4 * i), f[i]);
  endtask : acc_io

  task automatic run_op(input logic [31:0] op, input int cyc);
    int n;
    n = 0;
    bus(1'b1, OFF_OPCODE, op);
    while (busy === 1'b1 && n < 64)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    check("busy cycles", 32'(cyc), 32'(n));
    if (n >= 64)
      give_verdict();
  endtask : run_op

  task automatic do_op(input logic [31:0] op, input logic [7:0] a,
                       input logic [15:0] st, input logic [55:0] v,
                       input logic [55:0] ev, input logic [15:0] es,
                       input int cyc);
    acc_io(1'b1, a, v);
    bus(1'b1, OFF_STATUS, {16'h0, st});
    run_op(op, cyc);
    acc_io(1'b0, a, ev);
    chk_reg(OFF_STATUS, {16'h0, es});
  endtask : do_op

  task automatic s_abs_move;
    bus(1'b1, OFF_INT_CLR, 32'h7);
    bus(1'b1, OFF_INT_EN, 32'h1);
    do_op(32'h526, OFF_A_EXT, 16'h0, 56'hff_ffffff_fffff2,
          56'he, 16'h10, T_MV);
    chk_reg(OFF_MOVE_HI, 32'hffffff);
    chk_reg(OFF_MOVE_LO, 32'hfffff2);
    chk_reg(OFF_INT_ST, 32'h1);
    check("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, OFF_INT_EN, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, OFF_INT_EN, 32'h1);
    bus(1'b1, OFF_INT_CLR, 32'h1);
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask : s_abs_move

  task automatic s_abs_cases;
    do_op(32'h26, OFF_A_EXT, 16'h0, 56'h80_000000_000000,
          56'h80_000000_000000, 16'h7a, 2);
    chk_reg(OFF_INT_ST, 32'h3);
    do_op(32'h2e, OFF_B_EXT, 16'h400, 56'h0, 56'h0, 16'h414, 2);
    do_op(32'h26, OFF_A_EXT, 16'h841, 56'h00_400000_000000,
          56'h00_400000_000000, 16'h861, 2);
  endtask : s_abs_cases

  task automatic s_adc;
    bus(1'b1, OFF_Y_HI, 32'h0);
    bus(1'b1, OFF_Y_LO, 32'h1);
    do_op(32'h39, OFF_B_EXT, 16'h1, 56'hff_ffffff_ffffff,
          56'h1, 16'h11, 2);
    bus(1'b1, OFF_X_HI, 32'h800000);
    bus(1'b1, OFF_X_LO, 32'h0);
    do_op(32'h21, OFF_A_EXT, 16'h400, 56'h0,
          56'hff_800000_000000, 16'h498, 2);
  endtask : s_adc

  task automatic s_move_only;
    do_op(32'h700, OFF_B_EXT, 16'h5, 56'h12_345678_9abcde,
          56'h12_345678_9abcde, 16'h5, T_MV);
    chk_reg(OFF_MOVE_HI, 32'h345678);
    chk_reg(OFF_MOVE_LO, 32'h9abcde);
    // Non-raw move of an out-of-range value is limited and sets L
    do_op(32'h100, OFF_A_EXT, 16'h0, 56'h01_000000_000000,
          56'h01_000000_000000, 16'h40, T_MV);
    chk_reg(OFF_MOVE_HI, 32'h7fffff);
    chk_reg(OFF_MOVE_LO, 32'hffffff);
    // Scale-down mode shifts the non-raw move right by one
    do_op(32'h100, OFF_A_EXT, 16'h400, 56'h2, 56'h2, 16'h400, T_MV);
    chk_reg(OFF_MOVE_HI, 32'h0);
    chk_reg(OFF_MOVE_LO, 32'h1);
  endtask : s_move_only

  task automatic s_refuse;
    bus(1'b1, OFF_INT_CLR, 32'h7);
    acc_io(1'b1, OFF_A_EXT, 56'h0);
    bus(1'b1, OFF_OPCODE, 32'h126);
    // Lands while the operation still runs, so it must be ignored
    bus(1'b1, OFF_A_EXT, 32'h55);
    repeat (T_MV) @(posedge pclk);
    #1;
    check("busy done", 32'h0, {31'h0, busy});
    chk_reg(OFF_A_EXT, 32'h0);
    chk_reg(OFF_INT_ST, 32'h5);
    bus(1'b0, 8'h48, 32'h0);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, r);
  endtask : s_refuse

  initial
  begin
    err_count = 0;
    compares  = 0;
    pclk      = 1'b0;
    presetn   = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(OFF_STATUS, 32'h0);
    s_abs_move();
    s_abs_cases();
    s_adc();
    s_move_only();
    s_refuse();
    give_verdict();
  end
endmodule : test_abs_adc_accumulator_alu_ops
